// ### design/sdf_pkg.sv
// Constants shared by the sigma-delta filter front control block
package sdf_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          CB_W        = 5;
  localparam int          RATE_W      = 3;
  localparam int          STAT_W      = 4;
  localparam int          RES_W       = 24;
  localparam int          DEC_W       = 10;

  // Register byte offsets
  localparam logic [7:0]  CFG_OFS     = 8'h00;
  localparam logic [7:0]  STAT_OFS    = 8'h04;
  localparam logic [7:0]  MASK_OFS    = 8'h08;
  localparam logic [7:0]  RES_OFS     = 8'h0C;
  localparam logic [7:0]  STATE_OFS   = 8'h10;

  // Configuration word fields
  localparam int          CB_LSB      = 0;
  localparam int          RATE_LSB    = 5;

  // Status / mask bit positions
  localparam int          ST_OVR      = 0;
  localparam int          ST_EXTERR   = 1;
  localparam int          ST_CLR      = 2;
  localparam int          ST_DRDY     = 3;
  localparam logic [3:0]  MASK_RST    = 4'h0;

  // Control bus codes
  localparam logic [2:0]  CB_GAIN_MAX = 3'h4;
  localparam logic [2:0]  CB_AMP_STBY = 3'h5;
  localparam logic [1:0]  CB_CHIP_PD  = 2'h3;

  // Clocking and decimation
  localparam int          CLK_HZ      = 10000000;
  localparam int          MCLK_DIV    = 4;
  localparam logic [1:0]  DIV_LAST    = 2'(MCLK_DIV - 1);
  localparam logic [1:0]  SAMPLE_PH   = 2'h1;
  localparam logic [9:0]  DEC_BASE    = 10'h010;
  localparam logic [2:0]  RATE_MAX    = 3'h6;
  localparam logic [1:0]  CFG_SETTLE  = 2'h2;
endpackage : sdf_pkg

// ### design/sdf_clk_div.sv
// Divide-by-four modulator clock generator with sample strobe
`timescale 1ns/100ps
module sdf_clk_div (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      mclk_r,
  output logic      strobe_r
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       mclk_nxt;
  logic       strobe_nxt;

  // Stopped clock parks low: the modulator draws least current there
  always_comb begin
    if (!run) begin
      cnt_nxt = 2'h0;
    end else if (cnt_r == sdf_pkg::DIV_LAST) begin
      cnt_nxt = 2'h0;
    end else begin
      cnt_nxt = cnt_r + 2'h1;
    end
    mclk_nxt   = run & cnt_nxt[1];
    strobe_nxt = run & (cnt_r == sdf_pkg::SAMPLE_PH);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r    <= 2'h0;
      mclk_r   <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      mclk_r   <= mclk_nxt;
      strobe_r <= strobe_nxt;
    end
  end
endmodule : sdf_clk_div

// ### design/sdf_cfg_hold.sv
// Configuration holder: pin or software source, applied whole
`timescale 1ns/100ps
module sdf_cfg_hold (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   hw_mode,
  input  wire logic [sdf_pkg::CB_W-1:0]   pin_cb,
  input  wire logic [sdf_pkg::RATE_W-1:0] pin_rate,
  input  wire logic                   wr,
  input  wire logic [sdf_pkg::CB_W-1:0]   wr_cb,
  input  wire logic [sdf_pkg::RATE_W-1:0] wr_rate,
  output logic [sdf_pkg::CB_W-1:0]        cb_r,
  output logic [sdf_pkg::RATE_W-1:0]      rate_r
);
  logic [sdf_pkg::CB_W-1:0]   cb_nxt;
  logic [sdf_pkg::RATE_W-1:0] rate_nxt;
  logic [7:0]                 pin_prev_r;
  logic [1:0]                 stable_r;
  logic [1:0]                 stable_nxt;
  logic [7:0]                 pin_now;

  assign pin_now = {pin_rate, pin_cb};

  // Pins must hold still before use so skew shows no torn code, save the raw pin load during reset
  always_comb begin
    cb_nxt   = cb_r;
    rate_nxt = rate_r;
    if (pin_now != pin_prev_r) begin
      stable_nxt = 2'h0;
    end else if (stable_r != sdf_pkg::CFG_SETTLE) begin
      stable_nxt = stable_r + 2'h1;
    end else begin
      stable_nxt = stable_r;
    end
    if (hw_mode) begin
      if (stable_r == sdf_pkg::CFG_SETTLE) begin
        cb_nxt   = pin_prev_r[4:0];
        rate_nxt = pin_prev_r[7:5];
      end
    end else if (wr) begin
      cb_nxt   = wr_cb;
      rate_nxt = wr_rate;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cb_r       <= pin_cb;
      rate_r     <= pin_rate;
      pin_prev_r <= pin_now;
      stable_r   <= 2'h0;
    end else begin
      cb_r       <= cb_nxt;
      rate_r     <= rate_nxt;
      pin_prev_r <= pin_now;
      stable_r   <= stable_nxt;
    end
  end
endmodule : sdf_cfg_hold

// ### design/sdf_front_ctrl.sv
// Input-side control of the decimating filter: clocking, intake, status
`timescale 1ns/100ps
module sdf_front_ctrl (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [sdf_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [sdf_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [sdf_pkg::DATA_W-1:0]   reg_rdata,
  output logic                              irq,
  input  wire logic                         hw_mode_in,
  input  wire logic [sdf_pkg::CB_W-1:0]     ctrl_pins_in,
  input  wire logic [sdf_pkg::RATE_W-1:0]   rate_pins_in,
  input  wire logic                         sync_in,
  input  wire logic                         filter_powerdown_in,
  input  wire logic                         decimator_reset_in,
  input  wire logic                         modulator_bitstream_in,
  input  wire logic                         modulator_overrange_in,
  input  wire logic [sdf_pkg::RES_W-1:0]    filter_result_in,
  input  wire logic                         filter_result_valid_in,
  input  wire logic                         error_n_in,
  output logic                              error_n_out,
  output logic                              error_n_oe,
  output logic                              modulator_clock_out,
  output logic      [sdf_pkg::CB_W-1:0]     modulator_control_bus,
  output logic      [sdf_pkg::RATE_W-1:0]   rate_sel_out,
  output logic                              filter_sample_out,
  output logic                              filter_sample_valid,
  output logic                              filter_clear_out,
  output logic                              filter_run_out,
  output logic                              decimator_reset_out,
  output logic                              decim_tick_out
);
  // Bus decode
  logic                          cfg_wr;
  logic                          mask_wr;
  logic                          stat_rd;
  // Clock divider
  logic                          mclk;
  logic                          strobe;
  // Run control
  logic                          pd_r;
  logic                          sync_prev_r;
  logic                          sync_rise;
  logic                          run_r;
  logic                          run_nxt;
  // Decimation phase
  logic [sdf_pkg::DEC_W-1:0]     dec_cnt_r;
  logic [sdf_pkg::DEC_W-1:0]     dec_cnt_nxt;
  logic [sdf_pkg::DEC_W-1:0]     dec_last;
  logic [sdf_pkg::RATE_W-1:0]    rate_eff;
  logic                          clear_nxt;
  logic                          tick_nxt;
  logic                          clear_r;
  logic                          tick_r;
  logic                          sample_r;
  logic                          sample_nxt;
  logic                          sample_v_r;
  logic                          sample_v_nxt;
  logic                          dec_rst_r;
  // Status and registers
  logic [sdf_pkg::STAT_W-1:0]    stat_r;
  logic [sdf_pkg::STAT_W-1:0]    stat_nxt;
  logic [sdf_pkg::STAT_W-1:0]    stat_set;
  logic [sdf_pkg::STAT_W-1:0]    mask_r;
  logic [sdf_pkg::STAT_W-1:0]    mask_nxt;
  logic [sdf_pkg::RES_W-1:0]     result_r;
  logic [sdf_pkg::RES_W-1:0]     result_nxt;
  logic [sdf_pkg::DATA_W-1:0]    rdata_r;
  logic [sdf_pkg::DATA_W-1:0]    rdata_nxt;
  logic                          irq_r;
  logic                          irq_nxt;
  logic                          err_oe_r;
  logic                          err_oe_nxt;
  logic [sdf_pkg::CB_W-1:0]      cfg_cb;
  logic [sdf_pkg::RATE_W-1:0]    cfg_rate;
  logic                          amp_stby;
  logic                          chip_pd;

  assign cfg_wr  = reg_wr && (reg_addr == sdf_pkg::CFG_OFS);
  assign mask_wr = reg_wr && (reg_addr == sdf_pkg::MASK_OFS);
  assign stat_rd = reg_rd && (reg_addr == sdf_pkg::STAT_OFS);

  sdf_cfg_hold u_cfg (
    .clock    (clock),
    .rst      (rst),
    .hw_mode  (hw_mode_in),
    .pin_cb   (ctrl_pins_in),
    .pin_rate (rate_pins_in),
    .wr       (cfg_wr),
    .wr_cb    (reg_wdata[sdf_pkg::CB_LSB +: sdf_pkg::CB_W]),
    .wr_rate  (reg_wdata[sdf_pkg::RATE_LSB +: sdf_pkg::RATE_W]),
    .cb_r     (cfg_cb),
    .rate_r   (cfg_rate)
  );

  // Power-down gates the divider directly: the clock stops at once
  sdf_clk_div u_div (
    .clock    (clock),
    .rst      (rst),
    .run      (~pd_r),
    .mclk_r   (mclk),
    .strobe_r (strobe)
  );

  // The bus bits go out as held; the modulator decodes them itself
  assign modulator_control_bus = cfg_cb;
  assign rate_sel_out          = cfg_rate;
  assign modulator_clock_out   = mclk;
  // Decoded standby states, shown in the state register
  assign amp_stby = (cfg_cb[2:0] == sdf_pkg::CB_AMP_STBY);
  assign chip_pd  = (cfg_cb[2:1] == sdf_pkg::CB_CHIP_PD);

  assign sync_rise = sync_in & ~sync_prev_r;
  assign rate_eff  = (cfg_rate > sdf_pkg::RATE_MAX) ? sdf_pkg::RATE_MAX
                                                    : cfg_rate;
  assign dec_last  = (sdf_pkg::DEC_BASE << rate_eff) - 10'h001;

  // Run control and decimation phase
  always_comb begin
    run_nxt      = run_r;
    dec_cnt_nxt  = dec_cnt_r;
    clear_nxt    = 1'b0;
    tick_nxt     = 1'b0;
    sample_nxt   = sample_r;
    sample_v_nxt = 1'b0;
    if (pd_r) begin
      run_nxt = 1'b0;
    end else if (sync_rise) begin
      run_nxt = 1'b1;
    end
    if (decimator_reset_in) begin
      dec_cnt_nxt = '0;
    end else if (sync_rise && !pd_r
                 && (dec_cnt_r != '0 || !run_r)) begin
      dec_cnt_nxt = '0;
      clear_nxt   = 1'b1;
    end else if (strobe && run_r && !pd_r) begin
      // An aligned sync falls here and the count runs on
      if (dec_cnt_r >= dec_last) begin
        dec_cnt_nxt = '0;
        tick_nxt    = 1'b1;
      end else begin
        dec_cnt_nxt = dec_cnt_r + 10'h001;
      end
    end
    if (strobe && run_r && !pd_r) begin
      sample_nxt   = modulator_bitstream_in;
      sample_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pd_r        <= 1'b0;
      sync_prev_r <= 1'b0;
      run_r       <= 1'b1;
      dec_cnt_r   <= '0;
      clear_r     <= 1'b0;
      tick_r      <= 1'b0;
      sample_r    <= 1'b0;
      sample_v_r  <= 1'b0;
      dec_rst_r   <= 1'b0;
    end else begin
      pd_r        <= filter_powerdown_in;
      sync_prev_r <= sync_in;
      run_r       <= run_nxt;
      dec_cnt_r   <= dec_cnt_nxt;
      clear_r     <= clear_nxt;
      tick_r      <= tick_nxt;
      sample_r    <= sample_nxt;
      sample_v_r  <= sample_v_nxt;
      dec_rst_r   <= decimator_reset_in;
    end
  end

  assign filter_clear_out    = clear_r;
  assign decim_tick_out      = tick_r;
  assign filter_sample_out   = sample_r;
  assign filter_sample_valid = sample_v_r;
  assign filter_run_out      = run_r;
  assign decimator_reset_out = dec_rst_r;

  // Status, mask, result and read-back
  always_comb begin
    stat_set            = '0;
    stat_set[sdf_pkg::ST_OVR]    = modulator_overrange_in;
    // Ignore the pin while we pull it, else our own drive re-arms it
    stat_set[sdf_pkg::ST_EXTERR] = ~error_n_in & ~err_oe_r;
    stat_set[sdf_pkg::ST_CLR]    = clear_nxt;
    stat_set[sdf_pkg::ST_DRDY]   = filter_result_valid_in;
    // Set beats the clear-on-read in the same cycle
    stat_nxt   = (stat_rd ? '0 : stat_r) | stat_set;
    mask_nxt   = mask_wr ? reg_wdata[sdf_pkg::STAT_W-1:0] : mask_r;
    result_nxt = filter_result_valid_in ? filter_result_in
                                        : result_r;
    err_oe_nxt = stat_nxt[sdf_pkg::ST_OVR];
    irq_nxt    = |(stat_nxt & mask_nxt);
    rdata_nxt  = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        sdf_pkg::CFG_OFS:   rdata_nxt = {24'h000000, cfg_rate, cfg_cb};
        sdf_pkg::STAT_OFS:  rdata_nxt = {28'h0000000, stat_r};
        sdf_pkg::MASK_OFS:  rdata_nxt = {28'h0000000, mask_r};
        sdf_pkg::RES_OFS:   rdata_nxt = {8'h00, result_r};
        sdf_pkg::STATE_OFS: rdata_nxt = {16'h0000, chip_pd, amp_stby,
                                         run_r, pd_r, 2'h0, dec_cnt_r};
        default:            rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_r   <= '0;
      mask_r   <= sdf_pkg::MASK_RST;
      result_r <= '0;
      err_oe_r <= 1'b0;
      irq_r    <= 1'b0;
      rdata_r  <= '0;
    end else begin
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      result_r <= result_nxt;
      err_oe_r <= err_oe_nxt;
      irq_r    <= irq_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Open drain: the data leg only ever pulls low
  assign error_n_out = 1'b0;
  assign error_n_oe  = err_oe_r;
  assign irq         = irq_r;
  assign reg_rdata   = rdata_r;
endmodule : sdf_front_ctrl

// ### tb/sdf_front_ctrl_sva.sv
// Port-level assertions for the filter front control block
`timescale 1ns/100ps
module sdf_front_ctrl_sva (
  input wire logic                       clock,
  input wire logic                       rst,
  input wire logic [sdf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sdf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [sdf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       hw_mode_in,
  input wire logic                       sync_in,
  input wire logic                       filter_powerdown_in,
  input wire logic                       decimator_reset_in,
  input wire logic                       modulator_bitstream_in,
  input wire logic                       modulator_overrange_in,
  input wire logic                       error_n_out,
  input wire logic                       error_n_oe,
  input wire logic                       modulator_clock_out,
  input wire logic [sdf_pkg::CB_W-1:0]   modulator_control_bus,
  input wire logic [sdf_pkg::RATE_W-1:0] rate_sel_out,
  input wire logic                       filter_sample_out,
  input wire logic                       filter_sample_valid,
  input wire logic                       filter_clear_out,
  input wire logic                       filter_run_out,
  input wire logic                       decimator_reset_out
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);

  a_cfg_write:
    assert property (reg_wr && reg_addr == sdf_pkg::CFG_OFS && !hw_mode_in
      |=> {rate_sel_out, modulator_control_bus} == $past(reg_wdata[7:0]))
    else $error("control bus did not take the written word");
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");
  a_clear_cause:
    assert property (filter_clear_out |-> $past(sync_in) && !$past(sync_in, 2))
    else $error("filter clear without a sync rise");
  a_clear_pulse:
    assert property (filter_clear_out |=> !filter_clear_out)
    else $error("filter clear longer than one cycle");
  a_decim_reset:
    assert property (decimator_reset_in |=> decimator_reset_out
      && !filter_clear_out)
    else $error("decimator reset not held");
  a_ovr_error:
    assert property (modulator_overrange_in |=> error_n_oe && !error_n_out)
    else $error("overrange did not pull the error pin");
  a_sample_rate:
    assert property (filter_sample_valid |=> !filter_sample_valid [*3])
    else $error("samples closer than four cycles");
  a_sample_bit:
    assert property ($stable(modulator_bitstream_in) [*4]
      ##1 filter_sample_valid |-> filter_sample_out
      == $past(modulator_bitstream_in))
    else $error("sample differs from the bitstream");
  a_pd_stops:
    assert property (filter_powerdown_in [*3] |=> !modulator_clock_out
      && !filter_sample_valid && !filter_run_out)
    else $error("power-down did not stop the filter");

  c_clear: cover property (filter_clear_out);
  c_ovr: cover property (modulator_overrange_in ##1 error_n_oe);
  c_pd: cover property ($fell(filter_run_out));
  c_cfg: cover property (reg_wr && reg_addr == sdf_pkg::CFG_OFS);
endmodule : sdf_front_ctrl_sva

bind sdf_front_ctrl sdf_front_ctrl_sva i_sva (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_mode_in(hw_mode_in),
  .sync_in(sync_in), .filter_powerdown_in(filter_powerdown_in),
  .decimator_reset_in(decimator_reset_in),
  .modulator_bitstream_in(modulator_bitstream_in),
  .modulator_overrange_in(modulator_overrange_in),
  .error_n_out(error_n_out), .error_n_oe(error_n_oe),
  .modulator_clock_out(modulator_clock_out),
  .modulator_control_bus(modulator_control_bus),
  .rate_sel_out(rate_sel_out), .filter_sample_out(filter_sample_out),
  .filter_sample_valid(filter_sample_valid),
  .filter_clear_out(filter_clear_out), .filter_run_out(filter_run_out),
  .decimator_reset_out(decimator_reset_out));

// ### tb/sdf_mod_model.sv
// Behavioural modulator answering the control bus and modulator clock
`timescale 1ns/100ps
module sdf_mod_model (
  input  wire logic                      mclk,
  input  wire logic [sdf_pkg::CB_W-1:0]  ctrl_bus,
  input  wire logic                      ovr_req,
  output logic                           bit_out,
  output logic                           ovr_out,
  output int                             rises
);
  logic [2:0] ph_r = 3'h0;
  int         cnt  = 0;
  // A fully powered-down modulator freezes its loop, so density halts
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    if (ctrl_bus[2:1] != sdf_pkg::CB_CHIP_PD) begin
      ph_r <= ph_r + 3'h1;
    end
  end
  assign bit_out = ph_r[2];
  assign ovr_out = ovr_req;
  assign rises   = cnt;
endmodule : sdf_mod_model

// ### tb/test_sdf_front_ctrl.sv
// Self-checking bench for the filter front control block
`timescale 1ns/100ps
`define chk(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("unexpected at %0t: got %h want %h", $time, g, e); \
    end \
  end
module test_sdf_front_ctrl;
  logic        clock, rst, reg_wr, reg_rd, hw_mode_in, sync_in, irq;
  logic        filter_powerdown_in, decimator_reset_in, ovr_req;
  logic        filter_result_valid_in, error_n_out, error_n_oe;
  logic        modulator_bitstream_in, modulator_overrange_in;
  logic        modulator_clock_out, filter_clear_out, decim_tick_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0]  ctrl_pins_in, modulator_control_bus, c;
  logic [2:0]  rate_pins_in, rate_sel_out;
  logic [23:0] filter_result_in;
  // Open-drain error line with its pull-up
  wire         error_n_in = error_n_oe ? error_n_out : 1'b1;
  int          n_fail = 0, tests_run = 0, n_clr = 0, rises, r0;

  sdf_front_ctrl i_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .hw_mode_in, .ctrl_pins_in, .rate_pins_in,
    .sync_in, .filter_powerdown_in, .decimator_reset_in,
    .modulator_bitstream_in, .modulator_overrange_in, .filter_result_in,
    .filter_result_valid_in, .error_n_in, .error_n_out, .error_n_oe,
    .modulator_clock_out, .modulator_control_bus, .rate_sel_out,
    .filter_sample_out(), .filter_sample_valid(), .filter_clear_out,
    .filter_run_out(), .decimator_reset_out(), .decim_tick_out);
  sdf_mod_model i_mod (.mclk(modulator_clock_out),
    .ctrl_bus(modulator_control_bus), .ovr_req(ovr_req),
    .bit_out(modulator_bitstream_in), .ovr_out(modulator_overrange_in),
    .rises(rises));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) if (filter_clear_out === 1'b1) n_clr <= n_clr + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `chk(d, e)
  endtask : rdc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {reg_wr, reg_rd, hw_mode_in, sync_in, filter_powerdown_in, ovr_req,
     decimator_reset_in, filter_result_valid_in, reg_addr, reg_wdata,
     rate_pins_in, filter_result_in} = '0;
    rst          = 1'b1;
    ctrl_pins_in = 5'h13;
    cyc(7);
    @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    `chk(modulator_control_bus, 5'h13)
    rdc(sdf_pkg::STAT_OFS, 32'h0);
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wr(sdf_pkg::CFG_OFS, {24'h0, 3'(i), c});
      `chk({rate_sel_out, modulator_control_bus}, {3'(i), c})
      rd(sdf_pkg::STATE_OFS);
      `chk(d[15:14], {c[2:1] == 2'h3, c[2:0] == 3'h5})
    end
    wr(sdf_pkg::CFG_OFS, 32'h0);
    @(posedge clock);
    hw_mode_in   <= 1'b1;
    ctrl_pins_in <= 5'h0A;
    cyc(6);
    wr(sdf_pkg::CFG_OFS, 32'h1F);
    cyc(1);
    `chk(modulator_control_bus, 5'h0A)
    @(posedge clock);
    hw_mode_in <= 1'b0;
    r0 = rises;
    cyc(40);
    `chk(rises - r0, 10)
    wr(sdf_pkg::MASK_OFS, 32'h4);
    repeat (200) begin
      @(posedge clock);
      #1;
      if (decim_tick_out === 1'b1) break;
    end
    `chk(decim_tick_out, 1'b1)
    r0 = n_clr;
    @(posedge clock);
    sync_in <= 1'b1;
    cyc(4);
    `chk(n_clr, r0)
    @(posedge clock);
    sync_in <= 1'b0;
    cyc(9);
    @(posedge clock);
    sync_in <= 1'b1;
    cyc(3);
    `chk(n_clr, r0 + 1)
    `chk(irq, 1'b1)
    rdc(sdf_pkg::STAT_OFS, 32'h4);
    cyc(1);
    `chk(irq, 1'b0)
    @(posedge clock);
    sync_in            <= 1'b0;
    decimator_reset_in <= 1'b1;
    cyc(2);
    r0 = n_clr;
    @(posedge clock);
    sync_in <= 1'b1;
    cyc(3);
    `chk(n_clr, r0)
    rd(sdf_pkg::STATE_OFS);
    `chk(d[9:0], 10'h000)
    @(posedge clock);
    decimator_reset_in <= 1'b0;
    sync_in            <= 1'b0;
    wr(sdf_pkg::MASK_OFS, 32'h0);
    @(posedge clock);
    ovr_req <= 1'b1;
    @(posedge clock);
    ovr_req <= 1'b0;
    cyc(1);
    `chk(error_n_in, 1'b0)
    `chk(irq, 1'b0)
    wr(sdf_pkg::MASK_OFS, 32'h1);
    `chk(irq, 1'b1)
    rdc(sdf_pkg::STAT_OFS, 32'h1);
    `chk({error_n_oe, irq}, 2'h0)
    @(posedge clock);
    filter_result_in       <= 24'hA5C3E1;
    filter_result_valid_in <= 1'b1;
    @(posedge clock);
    filter_result_valid_in <= 1'b0;
    rdc(sdf_pkg::RES_OFS, 32'h00A5C3E1);
    rdc(sdf_pkg::STAT_OFS, 32'h8);
    wr(8'h14, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0);
    rdc(sdf_pkg::CFG_OFS, 32'h0A);
    @(posedge clock);
    filter_powerdown_in <= 1'b1;
    cyc(3);
    r0 = rises;
    cyc(20);
    `chk(rises, r0)
    rd(sdf_pkg::STATE_OFS);
    `chk(d[13:12], 2'h1)
    @(posedge clock);
    filter_powerdown_in <= 1'b0;
    cyc(3);
    rd(sdf_pkg::STATE_OFS);
    `chk(d[13], 1'b0)
    @(posedge clock);
    sync_in <= 1'b1;
    cyc(3);
    rd(sdf_pkg::STATE_OFS);
    `chk(d[13:12], 2'h2)
    @(posedge clock);
    ctrl_pins_in <= 5'h15;
    rst          <= 1'b1;
    cyc(2);
    @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    `chk(modulator_control_bus, 5'h15)
    rdc(sdf_pkg::STAT_OFS, 32'h0);
    report_and_stop();
  end
endmodule : test_sdf_front_ctrl
